//--- bench/pmuseq_chk.sv
// port assertions of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pmuseq_regs.vh"
module pmuseq_chk #(
  parameter CONFIG_CYC = 10
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // pins
  input wire logic       chip_enable,
  input wire logic       reset_n,
  input wire logic       undervoltage_lockout,
  input wire logic [3:0] switcher_enable_pin,
  // register port
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // outputs
  input wire logic       rails_enable,
  input wire logic       comp_precharge,
  input wire logic [3:0] switcher_on,
  input wire logic [3:0] switching,
  input wire logic [3:0] low_side_first
);
  logic        single;
  logic [31:0] since_pre;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // single-enable mode and precharge age
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      single    <= 1'b0;
      since_pre <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `PMUSEQ_ENABLE_PIN_CONFIG)
        single <= (reg_wdata[1:0] == `PMUSEQ_PINCFG_SINGLE);
      if (!comp_precharge)
        since_pre <= 32'h0;
      else if (since_pre != 32'hFFFF_FFFF)
        since_pre <= since_pre + 32'h1;
    end
  end
  AST_IDLE_OFF: assert property (!chip_enable[*6] |-> !rails_enable && switcher_on == 4'h0)
    else $error("outputs up while chip disabled");
  AST_ON_NEEDS_RAILS: assert property (|switcher_on |-> rails_enable)
    else $error("switcher on without rails");
  AST_PRECHARGE_CAUSE: assert property ($rose(comp_precharge) |-> $past(reset_n) && rails_enable)
    else $error("precharge without reset release");
  AST_CONFIG_FIRST: assert property ($rose(|switcher_on) |-> since_pre >= CONFIG_CYC)
    else $error("switcher on before config load ended");
  AST_UNDERVOLTAGE_LOCKOUT_HOLD: assert property (undervoltage_lockout[*4] |-> (switcher_on & ~$past(switcher_on)) == 4'h0)
    else $error("start-up under lockout");
  AST_PIN_GATE: assert property (!switcher_enable_pin[0][*4] |-> !switcher_on[0])
    else $error("switcher on with its pin low");
  AST_SINGLE_GATE: assert property ((single && !switcher_enable_pin[0])[*4] |-> switcher_on == 4'h0)
    else $error("sequence enable pin ignored");
  AST_WRITE_READ: assert property ((reg_wr && reg_addr == `PMUSEQ_RESET_RELEASE_DELAY) ##1
    (reg_addr == `PMUSEQ_RESET_RELEASE_DELAY) |-> reg_rdata == $past(reg_wdata))
    else $error("reset delay register lost write");
  AST_FIRST_LOW: assert property ($rose(switching[0]) |-> ##[0:2] low_side_first[0])
    else $error("first pulse not low side");
endmodule // pmuseq_chk
bind pmuseq_top pmuseq_chk #(.CONFIG_CYC(CONFIG_CYC)) i_pmuseq_chk (.clk(clk), .sys_rst(sys_rst),
  .chip_enable(chip_enable), .reset_n(reset_n), .undervoltage_lockout(undervoltage_lockout),
  .switcher_enable_pin(switcher_enable_pin), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rails_enable(rails_enable),
  .comp_precharge(comp_precharge), .switcher_on(switcher_on), .switching(switching),
  .low_side_first(low_side_first));
`default_nettype wire

//--- bench/pmuseq_far.sv
// board-side controller: reset release and power-good answers
`timescale 1ns/1ps
`default_nettype none
module pmuseq_far (
  // clock
  input  wire logic       clk,
  // device side
  input  wire logic       rails_enable,
  input  wire logic [3:0] switcher_on,
  // answer speed
  input  wire logic [7:0] pg_lag,
  // driven pins
  output var  logic       reset_n,
  output var  logic [3:0] power_good
);
  logic [7:0] age [4];
  initial begin
    reset_n    = 1'b0;
    power_good = 4'h0;
    for (int i = 0; i < 4; i++) age[i] = 8'h00;
  end
  always @(negedge clk) begin
    // early release removes the extra wait
    reset_n <= rails_enable;
    for (int i = 0; i < 4; i++) begin
      if (!switcher_on[i]) age[i] <= 8'h00;
      else if (age[i] != 8'hFF) age[i] <= age[i] + 8'h01;
      power_good[i] <= switcher_on[i] && (age[i] >= pg_lag);
    end
  end
endmodule // pmuseq_far
`default_nettype wire

//--- bench/tb.sv
// self-checking bench of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pmuseq_regs.vh"
module tb;
  localparam int MS = 8;
  logic clk = 0, sys_rst = 1, chip_enable = 0, undervoltage_lockout = 1, reg_wr = 0, rd_stb = 0;
  logic reset_n, rails_enable, comp_precharge;
  logic [3:0] switcher_enable_pin = 0, last_on = 0, power_good, switcher_on, switching;
  logic [3:0] low_side_first, ss_done;
  logic [7:0] reg_addr = 0, reg_wdata = 0, pg_lag = 1, reg_rdata;
  logic [31:0] soft_start_pin = 0, feedback_level = 0, ss_ref, vout_setting;
  logic [15:0] low_side_width;
  logic [7:0] rd_q[$];
  logic [3:0] on_q[$];
  int miscompares = 0, compares = 0, seed = 59, cyc = 0, t_last = 0, gap_lo = 0, gap_hi = 0;
  always #5 clk = ~clk;
  pmuseq_top #(.START_CYC(4), .CONFIG_CYC(16), .MS_CYC(MS)) i_pmuseq_top (.clk(clk),
    .sys_rst(sys_rst), .chip_enable(chip_enable), .reset_n(reset_n),
    .undervoltage_lockout(undervoltage_lockout), .switcher_enable_pin(switcher_enable_pin),
    .power_good(power_good), .soft_start_pin(soft_start_pin), .feedback_level(feedback_level),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rails_enable(rails_enable), .comp_precharge(comp_precharge), .switcher_on(switcher_on),
    .ss_ref(ss_ref), .switching(switching), .low_side_first(low_side_first),
    .low_side_width(low_side_width), .ss_done(ss_done), .vout_setting(vout_setting));
  pmuseq_far i_pmuseq_far (.clk(clk), .rails_enable(rails_enable), .switcher_on(switcher_on),
    .pg_lag(pg_lag), .reset_n(reset_n), .power_good(power_good));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    rd_stb = 1;
    rd_q.push_back(exp);
    @(negedge clk);
    rd_stb = 0;
  endtask
  // power up, hold lockout, then release pins; wait for the expected enables
  task automatic run(input logic [3:0] pins, input logic [3:0] fin);
    int n;
    feedback_level = $random(seed) & 32'h1F1F_1F1F;
    soft_start_pin = $random(seed) | 32'h8080_8080;
    chip_enable = 1;
    repeat (60) @(negedge clk);
    undervoltage_lockout = 0;
    switcher_enable_pin = pins;
    n = 0;
    while (on_q.size() != 0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (on_q.size() != 0) check("sequence", 8'h00, 8'h01);
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) check("vout_setting", vout_setting[i*8 +: 8], 8'(4 * i + 1));
    check("ss_done", {4'h0, ss_done}, {4'h0, fin});
    check("switching", {4'h0, switching}, {4'h0, fin});
    check("comp_precharge", {7'h00, comp_precharge}, 8'h01);
    check("rails_enable", {7'h00, rails_enable}, 8'h01);
    on_q.push_back(4'h0);
    chip_enable = 0;
    undervoltage_lockout = 1;
    switcher_enable_pin = 4'h0;
    repeat (20) @(negedge clk);
    if (on_q.size() != 0) check("idle", 8'h00, 8'h01);
  endtask
  // compares results in the order they were noted
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_stb) check("reg_rdata", reg_rdata, rd_q.pop_front());
    if (!sys_rst && switcher_on !== last_on) begin
      last_on <= switcher_on;
      t_last <= cyc;
      if (last_on != 4'h0 && switcher_on != 4'h0)
        check("gap", 8'((cyc - t_last) >= gap_lo && (cyc - t_last) <= gap_hi), 8'h01);
      if (on_q.size() == 0) check("switcher_on", {4'h0, switcher_on}, 8'hFF);
      else check("switcher_on", {4'h0, switcher_on}, {4'h0, on_q.pop_front()});
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    rd(8'h00, 8'h00);
    rd(`PMUSEQ_ENABLE_PIN_CONFIG, 8'h00);
    rd(`PMUSEQ_POWER_UP_ORDER, 8'h00);
    rd(`PMUSEQ_RESET_RELEASE_DELAY, 8'h01);
    rd(`PMUSEQ_TURN_ON_OFF_DELAY, 8'h05);
    // fixed delay, order 3,1,0,2 with switcher 1 disabled
    wr(`PMUSEQ_POWER_UP_ORDER, 8'h87);
    wr(`PMUSEQ_TURN_ON_OFF_DELAY, 8'h01);
    wr(`PMUSEQ_RESET_RELEASE_DELAY, 8'h02);
    rd(`PMUSEQ_RESET_RELEASE_DELAY, 8'h02);
    wr(`PMUSEQ_SEQ_CONTROL, 8'h20);
    gap_lo = MS;
    gap_hi = MS + 3;
    on_q = '{4'h8, 4'h9, 4'hD};
    run(4'hF, 4'hD);
    // power-good dependent, order 3,2,1,0, slow answers
    wr(`PMUSEQ_SEQ_CONTROL, 8'h01);
    wr(`PMUSEQ_POWER_UP_ORDER, 8'h1B);
    pg_lag = 20;
    gap_lo = 20 + MS;
    gap_hi = 20 + MS + 8;
    on_q = '{4'h8, 4'hC, 4'hE, 4'hF};
    run(4'hF, 4'hF);
    // all together, gated by the sequence enable pin alone
    wr(`PMUSEQ_SEQ_CONTROL, 8'h00);
    wr(`PMUSEQ_POWER_UP_ORDER, 8'h00);
    wr(`PMUSEQ_ENABLE_PIN_CONFIG, 8'h02);
    on_q = '{4'hF};
    run(4'h1, 4'hF);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // tb
`default_nettype wire

//--- rtl/pmuseq_nvm.v
// small non-volatile configuration image with registered read port
`timescale 1ns/1ps
`default_nettype none
module pmuseq_nvm #(
  parameter AW = 4,
  parameter DW = 8
) (
  // clock
  input  wire          clk,
  // read port
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem[i] = i[DW-1:0];
    end
  end
  always @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // pmuseq_nvm
`default_nettype wire

//--- rtl/pmuseq_regs.vh
// register map, field positions, reset values and timing counts of the start-up sequencer
`ifndef PMUSEQ_REGS_VH
`define PMUSEQ_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define PMUSEQ_ENABLE_PIN_CONFIG    8'hD2
`define PMUSEQ_POWER_UP_ORDER       8'hD5
`define PMUSEQ_RESET_RELEASE_DELAY  8'hDC
`define PMUSEQ_TURN_ON_OFF_DELAY    8'hDD
`define PMUSEQ_TURN_ON_RAMP_RATE    8'hDE
`define PMUSEQ_SEQ_CONTROL          8'hE0
`define PMUSEQ_SEQ_STATUS           8'hE1
// ****************************************************************
// fields
// ****************************************************************
`define PMUSEQ_PINCFG_MODE_LSB      0
`define PMUSEQ_PINCFG_MODE_MSB      1
`define PMUSEQ_PINCFG_SINGLE        2'h2
`define PMUSEQ_CTL_PG_DEP_BIT       0
`define PMUSEQ_CTL_DIG_SS_BIT       1
`define PMUSEQ_CTL_DCM_ONLY_BIT     2
`define PMUSEQ_CTL_DIS_LSB          4
// ****************************************************************
// reset values
// ****************************************************************
`define PMUSEQ_PINCFG_RST           8'h00
`define PMUSEQ_ORDER_RST            8'h00
`define PMUSEQ_RSTDLY_RST           8'h01
`define PMUSEQ_TONOFF_RST           8'h05
`define PMUSEQ_RAMP_RST             8'h01
`define PMUSEQ_CTL_RST              8'h00
// ****************************************************************
// timing (100 MHz clock)
// ****************************************************************
`define PMUSEQ_CLK_PERIOD_NS        10
`define PMUSEQ_START_US             100
`define PMUSEQ_CONFIG_US            1100
`define PMUSEQ_MS_US                1000
`define PMUSEQ_START_CYC   ((`PMUSEQ_START_US * 1000) / `PMUSEQ_CLK_PERIOD_NS)
`define PMUSEQ_CONFIG_CYC  ((`PMUSEQ_CONFIG_US * 1000) / `PMUSEQ_CLK_PERIOD_NS)
`define PMUSEQ_MS_CYC      ((`PMUSEQ_MS_US * 1000) / `PMUSEQ_CLK_PERIOD_NS)
`define PMUSEQ_NVM_WORDS            16
`endif

//--- rtl/pmuseq_softstart.v
// per-switcher soft-start ramp, prebias hold and conduction-mode ramp
`timescale 1ns/1ps
`default_nettype none
`include "pmuseq_regs.vh"
module pmuseq_softstart #(
  parameter RW = 8
) (
  // clock and reset
  input  wire          clk,
  input  wire          sys_rst,
  // control
  input  wire          start,
  input  wire          digital_ss,
  input  wire          dcm_only,
  input  wire [7:0]    ramp_rate,
  input  wire [RW-1:0] target,
  input  wire [RW-1:0] soft_start_pin,
  input  wire [RW-1:0] feedback_level,
  // results
  output reg  [RW-1:0] ss_ref,
  output reg           switching,
  output reg           low_side_first,
  output reg  [3:0]    low_side_width,
  output reg           done
);
  reg [7:0]    step_cnt;
  reg          running;
  wire [RW-1:0] ramp = digital_ss ? ss_ref : soft_start_pin;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ss_ref         <= {RW{1'b0}};
      switching      <= 1'b0;
      low_side_first <= 1'b0;
      low_side_width <= 4'h0;
      done           <= 1'b0;
      step_cnt       <= 8'h00;
      running        <= 1'b0;
    end else if (!start) begin
      ss_ref         <= {RW{1'b0}};
      switching      <= 1'b0;
      low_side_first <= 1'b0;
      low_side_width <= 4'h0;
      done           <= 1'b0;
      step_cnt       <= 8'h00;
      running        <= 1'b0;
    end else begin
      running        <= 1'b1;
      low_side_first <= 1'b0;
      if (digital_ss && ss_ref < target) begin
        if (step_cnt >= ramp_rate) begin
          step_cnt <= 8'h00;
          ss_ref   <= ss_ref + {{(RW-1){1'b0}}, 1'b1};
        end else begin
          step_cnt <= step_cnt + 8'h01;
        end
      end
      if (running && ramp >= target) begin
        done <= 1'b1;
      end
      // prebias: hold off until ramp crosses feedback
      if (!switching && running && ramp > feedback_level) begin
        switching      <= 1'b1;
        low_side_first <= 1'b1;
      end
      if (switching && !dcm_only && low_side_width != 4'hF) begin
        low_side_width <= low_side_width + 4'h1;
      end
    end
  end
endmodule // pmuseq_softstart
`default_nettype wire

//--- rtl/pmuseq_top.v
// start-up and power sequencing controller for four switchers
// Functional notes
// - bring rails up, then await reset release
// - reset release starts precharge and config load
// - load voltage per switcher; frequency, soft-start, limit words are read but not kept
// - config load lasts 1.1 ms
// - programmable reset delay before sequencing
// - configurable order, programmable turn-on delay
// - default turn-on/off delays are 5 ms; here only turn-on is delayed, all switchers drop at once
// - default order starts all together
// - power-good mode waits power good plus delay
// - fixed mode counts from previous enable
// - disabled switchers are skipped
// - inhibit start-up under undervoltage lockout
// - pin config 10 makes single sequence enable
// - soft-start digital or by pin capacitor
// - reference starts at zero, ramps to target
// - no switching while feedback above ramp
// - first pulse low side, then discontinuous
// - continuous mode ramps low-side pulse width
`timescale 1ns/1ps
`default_nettype none
`include "pmuseq_regs.vh"
module pmuseq_top #(
  parameter RW         = 8,
  parameter START_CYC  = `PMUSEQ_START_CYC,
  parameter CONFIG_CYC = `PMUSEQ_CONFIG_CYC,
  parameter MS_CYC     = `PMUSEQ_MS_CYC
) (
  // clock and reset
  input  wire            clk,
  input  wire            sys_rst,
  // chip pins
  input  wire            chip_enable,
  input  wire            reset_n,
  input  wire            undervoltage_lockout,
  input  wire [3:0]      switcher_enable_pin,
  input  wire [3:0]      power_good,
  input  wire [4*RW-1:0] soft_start_pin,
  input  wire [4*RW-1:0] feedback_level,
  // register port
  input  wire            reg_wr,
  input  wire [7:0]      reg_addr,
  input  wire [7:0]      reg_wdata,
  output reg  [7:0]      reg_rdata,
  // rail and switcher outputs
  output reg             rails_enable,
  output reg             comp_precharge,
  output reg  [3:0]      switcher_on,
  output wire [4*RW-1:0] ss_ref,
  output wire [3:0]      switching,
  output wire [3:0]      low_side_first,
  output wire [15:0]     low_side_width,
  output wire [3:0]      ss_done,
  output wire [4*RW-1:0] vout_setting
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_RAILS  = 3'h1;
  localparam ST_WRST   = 3'h2;
  localparam ST_CONFIG = 3'h3;
  localparam ST_RDLY   = 3'h4;
  localparam ST_SEQ    = 3'h5;
  localparam ST_RUN    = 3'h6;
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [7:0] sync1;
  reg [7:0] sync2;
  reg [7:0] psync1;
  reg [7:0] psync2;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1  <= 8'h00;
      sync2  <= 8'h00;
      psync1 <= 8'h00;
      psync2 <= 8'h00;
    end else begin
      sync1  <= {power_good, undervoltage_lockout, reset_n, chip_enable, 1'b0};
      sync2  <= sync1;
      psync1 <= {4'h0, switcher_enable_pin};
      psync2 <= psync1;
    end
  end
  wire       ce_s   = sync2[1];
  wire       rstn_s = sync2[2];
  wire       undervoltage_lockout_s = sync2[3];
  wire [3:0] pg_s   = sync2[7:4];
  wire [3:0] en_s   = psync2[3:0];
  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] pin_cfg;
  reg [7:0] order;
  reg [7:0] rst_dly;
  reg [7:0] ton_dly;
  reg [7:0] ramp_rate;
  reg [7:0] ctl;
  reg [2:0] state;
  reg [2:0] pos;
  reg [31:0] cnt;
  reg [7:0]  ms_left;
  reg        waiting;
  reg [3:0]  cfg_idx;
  reg [RW-1:0] cfg_v [0:3];
  wire [7:0] nvm_data;
  function [1:0] slot_of;
    input [7:0] ord;
    input [1:0] n;
    begin
      slot_of = ord[2*n +: 2];
    end
  endfunction
  wire single_en = (pin_cfg[`PMUSEQ_PINCFG_MODE_MSB:`PMUSEQ_PINCFG_MODE_LSB]
                    == `PMUSEQ_PINCFG_SINGLE);
  wire [3:0] gate_en = single_en ? {4{en_s[0]}} : en_s;
  wire [3:0] disabled = ctl[`PMUSEQ_CTL_DIS_LSB +: 4];
  wire       pg_dep = ctl[`PMUSEQ_CTL_PG_DEP_BIT];
  wire       simul  = (order == 8'h00);
  wire [1:0] cur_sw = slot_of(order, pos[1:0]);
  wire [1:0] prv_sw = slot_of(order, pos[1:0] - 2'h1);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_cfg   <= `PMUSEQ_PINCFG_RST;
      order     <= `PMUSEQ_ORDER_RST;
      rst_dly   <= `PMUSEQ_RSTDLY_RST;
      ton_dly   <= `PMUSEQ_TONOFF_RST;
      ramp_rate <= `PMUSEQ_RAMP_RST;
      ctl       <= `PMUSEQ_CTL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `PMUSEQ_ENABLE_PIN_CONFIG:   pin_cfg   <= reg_wdata;
        `PMUSEQ_POWER_UP_ORDER:      order     <= reg_wdata;
        `PMUSEQ_RESET_RELEASE_DELAY: rst_dly   <= reg_wdata;
        `PMUSEQ_TURN_ON_OFF_DELAY:   ton_dly   <= reg_wdata;
        `PMUSEQ_TURN_ON_RAMP_RATE:   ramp_rate <= reg_wdata;
        `PMUSEQ_SEQ_CONTROL:         ctl       <= reg_wdata;
        default: ;
      endcase
    end
  end
  always @* begin
    case (reg_addr)
      `PMUSEQ_ENABLE_PIN_CONFIG:   reg_rdata = pin_cfg;
      `PMUSEQ_POWER_UP_ORDER:      reg_rdata = order;
      `PMUSEQ_RESET_RELEASE_DELAY: reg_rdata = rst_dly;
      `PMUSEQ_TURN_ON_OFF_DELAY:   reg_rdata = ton_dly;
      `PMUSEQ_TURN_ON_RAMP_RATE:   reg_rdata = ramp_rate;
      `PMUSEQ_SEQ_CONTROL:         reg_rdata = ctl;
      `PMUSEQ_SEQ_STATUS:          reg_rdata = {1'b0, state, switcher_on};
      default:                     reg_rdata = 8'h00;
    endcase
  end
  // ****************************************************************
  // configuration image
  // ****************************************************************
  pmuseq_nvm #(
    .AW (4),
    .DW (8)
  ) u_nvm (
    .clk     (clk),
    .rd_addr (cfg_idx),
    .rd_data (nvm_data)
  );
  // ****************************************************************
  // sequencer
  // ****************************************************************
  wire ms_tick = (cnt == 32'h0);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state          <= ST_IDLE;
      rails_enable   <= 1'b0;
      comp_precharge <= 1'b0;
      switcher_on    <= 4'h0;
      pos            <= 3'h0;
      cnt            <= 32'h0;
      ms_left        <= 8'h00;
      waiting        <= 1'b0;
      cfg_idx        <= 4'h0;
      cfg_v[0]       <= {RW{1'b0}};
      cfg_v[1]       <= {RW{1'b0}};
      cfg_v[2]       <= {RW{1'b0}};
      cfg_v[3]       <= {RW{1'b0}};
    end else begin
      if (!ce_s || undervoltage_lockout_s) begin
        state          <= ST_IDLE;
        rails_enable   <= 1'b0;
        comp_precharge <= 1'b0;
        switcher_on    <= 4'h0;
      end else begin
        switcher_on <= switcher_on & gate_en;
        case (state)
          ST_IDLE: begin
            rails_enable <= 1'b1;
            cnt          <= START_CYC - 1;
            state        <= ST_RAILS;
          end
          ST_RAILS: begin
            if (cnt == 32'h0) state <= ST_WRST;
            else cnt <= cnt - 32'h1;
          end
          ST_WRST: begin
            if (rstn_s) begin
              comp_precharge <= 1'b1;
              cnt            <= CONFIG_CYC - 1;
              cfg_idx        <= 4'h0;
              state          <= ST_CONFIG;
            end
          end
          ST_CONFIG: begin
            // four words per switcher: voltage in word 4n+1; frequency, soft-start, limit in the others
            cfg_idx <= cfg_idx + 4'h1;
            // read port lags one cycle: word 4n+1 stands while index is 4n+2
            if (cfg_idx[1:0] == 2'h2) cfg_v[cfg_idx[3:2]] <= nvm_data[RW-1:0];
            if (cnt == 32'h0) begin
              ms_left <= rst_dly;
              cnt     <= MS_CYC - 1;
              state   <= ST_RDLY;
            end else cnt <= cnt - 32'h1;
          end
          ST_RDLY: begin
            cnt <= ms_tick ? MS_CYC - 1 : cnt - 32'h1;
            if (ms_left == 8'h00) begin
              pos     <= 3'h0;
              waiting <= 1'b0;
              state   <= ST_SEQ;
            end else if (ms_tick) ms_left <= ms_left - 8'h01;
          end
          ST_SEQ: begin
            if (simul) begin
              switcher_on <= gate_en & ~disabled;
              state       <= ST_RUN;
            end else if (pos == 3'h4) begin
              state <= ST_RUN;
            end else if (disabled[cur_sw]) begin
              pos <= pos + 3'h1;
            end else if (!waiting) begin
              // first slot, fixed mode, or previous switcher power good or disabled: delay starts here
              if (pos == 3'h0 || !pg_dep || disabled[prv_sw] || pg_s[prv_sw]) begin
                waiting <= 1'b1;
                ms_left <= ton_dly;
                cnt     <= MS_CYC - 1;
              end
            end else begin
              cnt <= ms_tick ? MS_CYC - 1 : cnt - 32'h1;
              if (ms_left == 8'h00) begin
                if (gate_en[cur_sw]) begin
                  switcher_on[cur_sw] <= 1'b1;
                  waiting             <= 1'b0;
                  pos                 <= pos + 3'h1;
                end
              end else if (ms_tick) ms_left <= ms_left - 8'h01;
            end
          end
          ST_RUN: state <= ST_RUN;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
  // ****************************************************************
  // soft-start per switcher
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ss
      assign vout_setting[g*RW +: RW] = cfg_v[g];
      pmuseq_softstart #(
        .RW (RW)
      ) u_ss (
        .clk            (clk),
        .sys_rst        (sys_rst),
        .start          (switcher_on[g]),
        .digital_ss     (ctl[`PMUSEQ_CTL_DIG_SS_BIT]),
        .dcm_only       (ctl[`PMUSEQ_CTL_DCM_ONLY_BIT]),
        .ramp_rate      (ramp_rate),
        .target         (cfg_v[g]),
        .soft_start_pin (soft_start_pin[g*RW +: RW]),
        .feedback_level (feedback_level[g*RW +: RW]),
        .ss_ref         (ss_ref[g*RW +: RW]),
        .switching      (switching[g]),
        .low_side_first (low_side_first[g]),
        .low_side_width (low_side_width[g*4 +: 4]),
        .done           (ss_done[g])
      );
    end
  endgenerate
endmodule // pmuseq_top
`default_nettype wire
